// File: rtl/ocd_defs.svh
`ifndef OCD_DEFS_SVH
`define OCD_DEFS_SVH
// Summary of operation
// - Destination bit 0 sends result to accumulator, 1 to file register.
// - Fast bit 1 on call or return uses shadow copies; 0 leaves them.
// - Table access modes: no change, post-increment, post-decrement, pre-increment.
// - Keep a 21-bit table pointer and an 8-bit table latch.
// - File-to-file move is two words, 12-bit source then destination.
// - Access bit 0 forces access bank; 1 takes bank select register.
// - Single-word byte and bit ops carry an 8-bit file address.
// - Bit ops select bit 0 to 7 with a 3-bit field.
// - Literal ops take 8-bit immediate from low byte, opcode above.
// - Literal fields are 8, 12 or 20 bits wide per instruction.
// - Branch field is relative displacement, or absolute for call/jump.
// - 7-bit source and destination offsets add to an indirect pointer.
// - Destination is 8-bit file address or 2-bit pointer selector.
// - Don't-care instruction bits never change what executes.
// - A second word executed alone behaves as a no-operation.
// - Taken test or program counter change adds one no-operation cycle.

// Register map, byte addresses
`define OCD_OFS_CTRL 8'h00
`define OCD_OFS_BANK 8'h04
`define OCD_OFS_TPTR 8'h08
`define OCD_OFS_TLAT 8'h0C
`define OCD_OFS_STAT 8'h10
// Reset values
`define OCD_RST_EN 1'b1
`define OCD_RST_BANK 4'h0
// Opcode patterns
`define OCD_TOP_W2 4'hF
`define OCD_TOP_F2F 4'hC
`define OCD_TOP_BRA 4'hD
`define OCD_TOP_ZERO 4'h0
`define OCD_TOP_BIT_LO 4'h7
`define OCD_TOP_BIT_HI 4'hB
`define OCD_TOP_BYTE_LO 4'h1
`define OCD_TOP_BYTE_HI 4'h6
`define OCD_OP_JUMP 8'hEF
`define OCD_OP_CALL 7'h76
`define OCD_OP_LDPTR 10'h3B8
`define OCD_OP_OFSMV 9'h1D7
`define OCD_OP_BCOND 5'h1C
`define OCD_OP_LIT 5'h01
`define OCD_OP_RET 15'h0009
`define OCD_OP_RETI 15'h0008
`define OCD_OP_TBL 13'h0001
// Access bank halves
`define OCD_ACC_LO_BANK 4'h0
`define OCD_ACC_HI_BANK 4'hF
`define OCD_ACC_SPLIT 8'h80
`endif

// File: rtl/ocd_pkg.sv
package ocd_pkg;
  // Decoder sequence, Gray coded along fetch, word2, flush
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_WORD2 = 2'b01,
    ST_FLUSH = 2'b11
  } ocd_state_t;
  // Two-word instruction awaiting its second word
  typedef enum logic [2:0] {
    PD_NONE, PD_F2F, PD_JUMP, PD_CALL, PD_LDPTR, PD_OFSMV
  } ocd_pend_t;
  // Table pointer modes
  typedef enum logic [1:0] {
    TM_NONE = 2'b00,
    TM_POSTINC = 2'b01,
    TM_POSTDEC = 2'b10,
    TM_PREINC = 2'b11
  } ocd_tmode_t;
  // Literal width carried by the decoded word
  typedef enum logic [1:0] {
    LW_NONE = 2'b00,
    LW_8 = 2'b01,
    LW_12 = 2'b10,
    LW_20 = 2'b11
  } ocd_litw_t;
endpackage : ocd_pkg

// File: rtl/ocd_tbl_ptr.sv
`timescale 1ns/1ps
`include "ocd_defs.svh"
module ocd_tbl_ptr import ocd_pkg::*; #(
  parameter int PTR_W = 21,
  parameter int LAT_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic go_wr,
  input ocd_tmode_t mode,
  input wire logic ld_ptr,
  input wire logic ld_lat,
  input wire logic [31:0] wdata,
  input wire logic [LAT_W-1:0] rdata,
  input wire logic rvalid,
  output logic [PTR_W-1:0] ptr,
  output logic [LAT_W-1:0] lat,
  output logic [PTR_W-1:0] addr,
  output logic req,
  output logic req_wr
);
  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic [LAT_W-1:0] lat;
    logic [PTR_W-1:0] addr;
    logic req;
    logic wr;
  } ocd_tbl_t;
  ocd_tbl_t tb_reg, tb_next;

  // Pointer update per access mode; memory read data lands in the latch
  always_comb begin
    tb_next = tb_reg;
    tb_next.req = 1'b0;
    if (ld_ptr) tb_next.ptr = wdata[PTR_W-1:0];
    if (ld_lat) tb_next.lat = wdata[LAT_W-1:0];
    if (rvalid) tb_next.lat = rdata;
    if (go) begin
      tb_next.req = 1'b1;
      tb_next.wr = go_wr;
      tb_next.addr = tb_reg.ptr;
      unique case (mode)
        TM_NONE: tb_next.ptr = tb_reg.ptr;
        TM_POSTINC: tb_next.ptr = tb_reg.ptr + PTR_W'(1);
        TM_POSTDEC: tb_next.ptr = tb_reg.ptr - PTR_W'(1);
        TM_PREINC: begin
          tb_next.ptr = tb_reg.ptr + PTR_W'(1);
          tb_next.addr = tb_reg.ptr + PTR_W'(1);
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) tb_reg <= '0;
    else tb_reg <= tb_next;
  end

  assign ptr = tb_reg.ptr;
  assign lat = tb_reg.lat;
  assign addr = tb_reg.addr;
  assign req = tb_reg.req;
  assign req_wr = tb_reg.wr;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_post_inc_ptr: assert property (
    go && !ld_ptr && mode == TM_POSTINC |=>
      req && addr == $past(ptr) && ptr == $past(ptr) + PTR_W'(1))
    else $error("post-increment access wrong");
  a_pre_inc_ptr: assert property (
    go && !ld_ptr && mode == TM_PREINC |=>
      addr == ptr && ptr == $past(ptr) + PTR_W'(1))
    else $error("pre-increment access wrong");
  a_ptr_hold: assert property (
    !go && !ld_ptr |=> ptr == $past(ptr))
    else $error("table pointer moved without access");
  c_tbl_dec: cover property (go && mode == TM_POSTDEC);
endmodule : ocd_tbl_ptr

// File: rtl/ocd_decode.sv
`timescale 1ns/1ps
`include "ocd_defs.svh"
module ocd_decode import ocd_pkg::*; #(
  parameter logic [7:0] ACC_SPLIT = `OCD_ACC_SPLIT
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  input wire logic cond_true,
  input wire logic [11:0] ind_ptr,
  input wire logic [7:0] tbl_rdata,
  input wire logic tbl_rvalid,
  output logic dec_valid,
  output logic dec_nop,
  output logic dec_byte,
  output logic dec_bit,
  output logic dec_dest_file,
  output logic [11:0] dec_file_addr,
  output logic [2:0] dec_bit_sel,
  output logic [19:0] dec_literal,
  output ocd_litw_t dec_lit_w,
  output logic [1:0] dec_ind_sel,
  output logic dec_br_rel,
  output logic dec_br_abs,
  output logic [19:0] dec_br_val,
  output logic dec_sh_save,
  output logic dec_sh_rest,
  output logic dec_move,
  output logic [11:0] dec_move_src,
  output logic [11:0] dec_move_dst,
  output logic tbl_req,
  output logic tbl_wr,
  output logic [20:0] tbl_addr,
  output logic [7:0] tbl_wdata
);
  typedef struct packed {
    ocd_state_t st;
    ocd_pend_t pend;
    logic [11:0] w1;
    logic en;
    logic [3:0] bank;
    logic [15:0] cnt;
    logic [31:0] rdata;
    logic dv;
    logic nop;
    logic byteop;
    logic bitop;
    logic dfile;
    logic [11:0] faddr;
    logic [2:0] bsel;
    logic [19:0] lit;
    ocd_litw_t litw;
    logic [1:0] isel;
    logic brrel;
    logic brabs;
    logic [19:0] brv;
    logic shsave;
    logic shrest;
    logic mvgo;
    logic [11:0] mvsrc;
    logic [11:0] mvdst;
    logic tblgo;
    logic tblwr;
    ocd_tmode_t tmode;
  } ocd_dec_t;
  ocd_dec_t r_reg, r_next;

  logic [15:0] w;
  logic [3:0] top;
  logic acc_wr;
  logic hit;
  logic wr_tptr;
  logic wr_tlat;
  logic [20:0] tptr_val;
  logic [7:0] tlat_val;

  // Full 12-bit file address from access bit and 8-bit field
  function automatic logic [11:0] bank_addr(input logic a,
                                            input logic [3:0] bank,
                                            input logic [7:0] f);
    if (a) bank_addr = {bank, f};
    else if (f < ACC_SPLIT) bank_addr = {`OCD_ACC_LO_BANK, f};
    else bank_addr = {`OCD_ACC_HI_BANK, f};
  endfunction : bank_addr

  assign w = instr_word;
  assign top = instr_word[15:12];

  // Zero-wait slave: every access phase completes at once
  assign pready = 1'b1;
  assign instr_ready = 1'b1;
  assign acc_wr = psel && penable && pwrite;
  assign hit = (paddr == `OCD_OFS_CTRL) || (paddr == `OCD_OFS_BANK) ||
               (paddr == `OCD_OFS_TPTR) || (paddr == `OCD_OFS_TLAT) ||
               (paddr == `OCD_OFS_STAT);
  assign pslverr = psel && penable && !hit;
  assign wr_tptr = acc_wr && (paddr == `OCD_OFS_TPTR);
  assign wr_tlat = acc_wr && (paddr == `OCD_OFS_TLAT);

  // Next-state logic: register access first, then one word per cycle
  always_comb begin
    r_next = r_reg;
    r_next.dv = 1'b0;
    r_next.nop = 1'b0;
    r_next.byteop = 1'b0;
    r_next.bitop = 1'b0;
    r_next.brrel = 1'b0;
    r_next.brabs = 1'b0;
    r_next.shsave = 1'b0;
    r_next.shrest = 1'b0;
    r_next.mvgo = 1'b0;
    r_next.tblgo = 1'b0;
    r_next.litw = LW_NONE;
    // Read data captured in setup so it is stable through access
    if (psel && !penable) begin
      unique case (paddr)
        `OCD_OFS_CTRL: r_next.rdata = {31'h0, r_reg.en};
        `OCD_OFS_BANK: r_next.rdata = {28'h0, r_reg.bank};
        `OCD_OFS_TPTR: r_next.rdata = {11'h0, tptr_val};
        `OCD_OFS_TLAT: r_next.rdata = {24'h0, tlat_val};
        `OCD_OFS_STAT:
          r_next.rdata = {11'h0, r_reg.pend, r_reg.st, r_reg.cnt};
        default: r_next.rdata = 32'h0;
      endcase
    end
    if (acc_wr && paddr == `OCD_OFS_CTRL) r_next.en = pwdata[0];
    if (acc_wr && paddr == `OCD_OFS_BANK) r_next.bank = pwdata[3:0];
    if (instr_valid) begin
      r_next.dv = 1'b1;
      r_next.cnt = r_reg.cnt + 16'h0001;
      unique case (r_reg.st)
        ST_FETCH: begin
          if (!r_reg.en || cond_true) begin
            // Slot after a taken test is squashed
            r_next.nop = 1'b1;
          end else if (top == `OCD_TOP_W2) begin
            r_next.nop = 1'b1;
          end else if (top == `OCD_TOP_F2F) begin
            r_next.w1 = w[11:0];
            r_next.pend = PD_F2F;
            r_next.st = ST_WORD2;
          end else if (w[15:8] == `OCD_OP_JUMP) begin
            r_next.w1 = {4'h0, w[7:0]};
            r_next.pend = PD_JUMP;
            r_next.st = ST_WORD2;
          end else if (w[15:9] == `OCD_OP_CALL) begin
            r_next.w1 = {3'h0, w[8:0]};
            r_next.pend = PD_CALL;
            r_next.st = ST_WORD2;
          end else if (w[15:6] == `OCD_OP_LDPTR) begin
            r_next.w1 = {6'h0, w[5:0]};
            r_next.pend = PD_LDPTR;
            r_next.st = ST_WORD2;
          end else if (w[15:7] == `OCD_OP_OFSMV) begin
            r_next.w1 = {5'h0, w[6:0]};
            r_next.pend = PD_OFSMV;
            r_next.st = ST_WORD2;
          end else if (w[15:11] == `OCD_OP_BCOND) begin
            // Taken or not is known later; cond_true squashes
            r_next.brrel = 1'b1;
            r_next.brv = 20'($signed(w[7:0]));
          end else if (top == `OCD_TOP_BRA) begin
            r_next.brrel = 1'b1;
            r_next.brv = 20'($signed(w[10:0]));
            r_next.st = ST_FLUSH;
          end else if (w[15:11] == `OCD_OP_LIT) begin
            r_next.lit = {12'h0, w[7:0]};
            r_next.litw = LW_8;
          end else if (w[15:1] == `OCD_OP_RET ||
                       w[15:1] == `OCD_OP_RETI) begin
            r_next.shrest = w[0];
            r_next.st = ST_FLUSH;
          end else if (w[15:3] == `OCD_OP_TBL) begin
            r_next.tblgo = 1'b1;
            r_next.tblwr = w[2];
            r_next.tmode = ocd_tmode_t'(w[1:0]);
          end else if (top >= `OCD_TOP_BIT_LO &&
                       top <= `OCD_TOP_BIT_HI) begin
            r_next.bitop = 1'b1;
            r_next.bsel = w[11:9];
            r_next.faddr = bank_addr(w[8], r_reg.bank, w[7:0]);
          end else if ((top >= `OCD_TOP_BYTE_LO &&
                        top <= `OCD_TOP_BYTE_HI) ||
                       (top == `OCD_TOP_ZERO && !w[11] &&
                        (|w[10:9]))) begin
            r_next.byteop = 1'b1;
            r_next.dfile = w[9];
            r_next.faddr = bank_addr(w[8], r_reg.bank, w[7:0]);
          end else begin
            r_next.nop = 1'b1;
          end
        end
        ST_WORD2: begin
          r_next.st = ST_FETCH;
          r_next.pend = PD_NONE;
          if (top != `OCD_TOP_W2) begin
            // Broken pair: drop it rather than guess
            r_next.nop = 1'b1;
          end else begin
            unique case (r_reg.pend)
              PD_F2F: begin
                r_next.mvgo = 1'b1;
                r_next.mvsrc = r_reg.w1;
                r_next.mvdst = w[11:0];
              end
              PD_JUMP, PD_CALL: begin
                r_next.brabs = 1'b1;
                r_next.brv = {w[11:0], r_reg.w1[7:0]};
                r_next.lit = {w[11:0], r_reg.w1[7:0]};
                r_next.litw = LW_20;
                r_next.shsave = (r_reg.pend == PD_CALL) &&
                                r_reg.w1[8];
                r_next.st = ST_FLUSH;
              end
              PD_LDPTR: begin
                r_next.lit = {8'h0, r_reg.w1[3:0], w[7:0]};
                r_next.litw = LW_12;
                r_next.isel = r_reg.w1[5:4];
              end
              PD_OFSMV: begin
                // Bits 11..7 of the second word are ignored
                r_next.mvgo = 1'b1;
                r_next.mvsrc = ind_ptr + {5'h0, r_reg.w1[6:0]};
                r_next.mvdst = ind_ptr + {5'h0, w[6:0]};
              end
              default: r_next.nop = 1'b1;
            endcase
          end
        end
        ST_FLUSH: begin
          r_next.nop = 1'b1;
          r_next.st = ST_FETCH;
        end
        default: r_next.st = ST_FETCH;
      endcase
    end else if (cond_true && r_reg.st == ST_FETCH) begin
      // Test resolved before the next word arrived
      r_next.st = ST_FLUSH;
    end
  end

  // Single state register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
      r_reg.en <= `OCD_RST_EN;
      r_reg.bank <= `OCD_RST_BANK;
    end else begin
      r_reg <= r_next;
    end
  end

  // Table pointer and latch, shared with the register port
  ocd_tbl_ptr #(.PTR_W(21), .LAT_W(8)) u_tbl (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .go(r_reg.tblgo),
    .go_wr(r_reg.tblwr),
    .mode(r_reg.tmode),
    .ld_ptr(wr_tptr),
    .ld_lat(wr_tlat),
    .wdata(pwdata),
    .rdata(tbl_rdata),
    .rvalid(tbl_rvalid),
    .ptr(tptr_val),
    .lat(tlat_val),
    .addr(tbl_addr),
    .req(tbl_req),
    .req_wr(tbl_wr)
  );

  assign tbl_wdata = tlat_val;
  assign prdata = r_reg.rdata;
  assign dec_valid = r_reg.dv;
  assign dec_nop = r_reg.nop;
  assign dec_byte = r_reg.byteop;
  assign dec_bit = r_reg.bitop;
  assign dec_dest_file = r_reg.dfile;
  assign dec_file_addr = r_reg.faddr;
  assign dec_bit_sel = r_reg.bsel;
  assign dec_literal = r_reg.lit;
  assign dec_lit_w = r_reg.litw;
  assign dec_ind_sel = r_reg.isel;
  assign dec_br_rel = r_reg.brrel;
  assign dec_br_abs = r_reg.brabs;
  assign dec_br_val = r_reg.brv;
  assign dec_sh_save = r_reg.shsave;
  assign dec_sh_rest = r_reg.shrest;
  assign dec_move = r_reg.mvgo;
  assign dec_move_src = r_reg.mvsrc;
  assign dec_move_dst = r_reg.mvdst;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_dest_select: assert property (
    dec_byte |-> dec_dest_file == $past(instr_word[9]))
    else $error("destination bit not honoured");
  a_shadow_only: assert property (
    dec_sh_rest |-> $past(instr_word[0]) && $past(r_reg.st) == ST_FETCH)
    else $error("shadow restore without fast bit");
  a_move_pair: assert property (
    dec_move && $past(r_reg.pend) == PD_F2F |->
      $past(instr_word[15:12]) == `OCD_TOP_W2 &&
      dec_move_dst == $past(instr_word[11:0]))
    else $error("two-word move decoded wrong");
  a_ofs_move: assert property (
    dec_move && $past(r_reg.pend) == PD_OFSMV |->
      dec_move_dst == $past(ind_ptr) + {5'h0, $past(instr_word[6:0])})
    else $error("indirect offset move wrong");
  a_access_bank: assert property (
    (dec_byte || dec_bit) && !$past(instr_word[8]) |->
      dec_file_addr[11:8] == (dec_file_addr[7:0] < ACC_SPLIT ?
        `OCD_ACC_LO_BANK : `OCD_ACC_HI_BANK))
    else $error("access bank not forced");
  a_bank_reg: assert property (
    (dec_byte || dec_bit) && $past(instr_word[8]) |->
      dec_file_addr[11:8] == $past(r_reg.bank))
    else $error("bank register not used");
  a_file_field: assert property (
    dec_byte || dec_bit |-> dec_file_addr[7:0] == $past(instr_word[7:0]))
    else $error("file address field wrong");
  a_bit_field: assert property (
    dec_bit |-> dec_bit_sel == $past(instr_word[11:9]))
    else $error("bit select field wrong");
  a_lit_byte: assert property (
    dec_lit_w == LW_8 |-> dec_literal == {12'h0, $past(instr_word[7:0])})
    else $error("8-bit literal wrong");
  a_lit_wide: assert property (
    dec_lit_w == LW_20 |-> dec_br_abs && dec_literal == dec_br_val)
    else $error("20-bit literal not paired with jump");
  a_word2_alone: assert property (
    instr_valid && r_reg.st == ST_FETCH &&
      instr_word[15:12] == `OCD_TOP_W2 |=> dec_nop && !dec_move)
    else $error("lone second word not a no-op");
  a_flush_slot: assert property (
    r_reg.st == ST_FLUSH && instr_valid |=>
      dec_nop && r_reg.st == ST_FETCH)
    else $error("flush slot not a single no-op");
  a_one_word: assert property (
    dec_valid && !dec_nop |-> $past(instr_valid))
    else $error("decode without a word");

  c_move_pair: cover property (dec_move && dec_valid);
  c_fast_call: cover property (dec_br_abs && dec_sh_save);
  c_tbl_read: cover property (tbl_req && !tbl_wr);
  c_skip: cover property (dec_byte ##1 cond_true && instr_valid);
endmodule : ocd_decode

// File: test/ocd_pmem_model.sv
`timescale 1ns/1ps
// Program memory behind the table port; answers at once or 3 cycles late
module ocd_pmem_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic tbl_req,
  input wire logic tbl_wr,
  input wire logic [20:0] tbl_addr,
  input wire logic [7:0] tbl_wdata,
  output logic [7:0] tbl_rdata,
  output logic tbl_rvalid,
  output logic [7:0] wr_byte
);
  logic busy_reg;
  logic [1:0] wait_reg;
  logic [20:0] addr_reg;

  // Byte content is a fixed scramble of the address; between answers the
  // data bus shows a toggling pattern so a stale sample never matches
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
      wait_reg <= 2'h0;
      addr_reg <= 21'h000000;
      tbl_rvalid <= 1'b0;
      tbl_rdata <= 8'h00;
      wr_byte <= 8'h00;
    end else begin
      tbl_rvalid <= 1'b0;
      tbl_rdata <= ~tbl_rdata;
      if (tbl_req && tbl_wr) begin
        wr_byte <= tbl_wdata;
      end
      if (tbl_req && !tbl_wr) begin
        busy_reg <= 1'b1;
        addr_reg <= tbl_addr;
        wait_reg <= slow ? 2'h3 : 2'h0;
      end else if (busy_reg) begin
        if (wait_reg == 2'h0) begin
          busy_reg <= 1'b0;
          tbl_rvalid <= 1'b1;
          tbl_rdata <= addr_reg[7:0] ^ 8'h5A;
        end else begin
          wait_reg <= wait_reg - 2'h1;
        end
      end
    end
  end
endmodule : ocd_pmem_model

// File: test/cpu_opcode_field_decode_tb_top.sv
`timescale 1ns/1ps
`include "ocd_defs.svh"
`define OCD_CHK(g, x) begin comparisons++; if ((g) !== (x)) begin n_fail++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (x)); end end
module cpu_opcode_field_decode_tb_top import ocd_pkg::*;;
  logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
  logic instr_valid, instr_ready, cond_true, tbl_rvalid, slow, dec_valid;
  logic dec_nop, dec_byte, dec_bit, dec_dest_file, dec_br_rel, dec_br_abs;
  logic dec_sh_save, dec_sh_rest, dec_move, tbl_req, tbl_wr;
  logic [7:0] paddr, tbl_rdata, tbl_wdata, wr_byte;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] instr_word;
  logic [11:0] ind_ptr, dec_file_addr, dec_move_src, dec_move_dst;
  logic [2:0] dec_bit_sel;
  logic [19:0] dec_literal, dec_br_val;
  logic [1:0] dec_ind_sel;
  logic [20:0] tbl_addr;
  ocd_litw_t dec_lit_w;
  int n_fail, comparisons;

  ocd_decode dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .cond_true(cond_true), .ind_ptr(ind_ptr),
    .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid), .dec_valid(dec_valid),
    .dec_nop(dec_nop), .dec_byte(dec_byte), .dec_bit(dec_bit),
    .dec_dest_file(dec_dest_file), .dec_file_addr(dec_file_addr),
    .dec_bit_sel(dec_bit_sel), .dec_literal(dec_literal),
    .dec_lit_w(dec_lit_w), .dec_ind_sel(dec_ind_sel),
    .dec_br_rel(dec_br_rel), .dec_br_abs(dec_br_abs),
    .dec_br_val(dec_br_val), .dec_sh_save(dec_sh_save),
    .dec_sh_rest(dec_sh_rest), .dec_move(dec_move),
    .dec_move_src(dec_move_src), .dec_move_dst(dec_move_dst),
    .tbl_req(tbl_req), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr),
    .tbl_wdata(tbl_wdata));

  ocd_pmem_model pmem_u (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow),
    .tbl_req(tbl_req), .tbl_wr(tbl_wr), .tbl_addr(tbl_addr),
    .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid),
    .wr_byte(wr_byte));

  // Free-running system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task tally_and_finish;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Offer one word, with or without a taken test; outputs settle after
  task automatic op(input logic [15:0] w, input logic c);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word <= w;
    cond_true <= c;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    cond_true <= 1'b0;
    #1;
  endtask : op

  // Bounded wait for a table request (0) or the memory answer (1)
  task automatic wait_on(input logic rv);
    int i;
    for (i = 0; i < 20; i++) begin
      if ((rv ? tbl_rvalid : tbl_req) === 1'b1) break;
      @(posedge sys_clk);
      #1;
    end
    if (i == 20) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : wait_on

  task automatic t_regs;
    apb(1'b0, `OCD_OFS_CTRL, 32'h0);
    `OCD_CHK(q, 32'h00000001)
    apb(1'b0, 8'h14, 32'h0);
    `OCD_CHK({e, q}, {1'b1, 32'h00000000})
    apb(1'b1, `OCD_OFS_TPTR, 32'hFFFFFFFF);
    apb(1'b0, `OCD_OFS_TPTR, 32'h0);
    `OCD_CHK(q, 32'h001FFFFF)
    apb(1'b1, `OCD_OFS_TLAT, 32'hFFFFFFFF);
    apb(1'b0, `OCD_OFS_TLAT, 32'h0);
    `OCD_CHK(q, 32'h000000FF)
    $display("t_regs done");
  endtask : t_regs

  task automatic t_fields;
    int i;
    logic [7:0] f;
    apb(1'b1, `OCD_OFS_BANK, 32'h00000005);
    // Both access-bank halves, one destination each, and the banked case with each destination
    for (i = 0; i < 4; i++) begin
      f = i[0] ? 8'h80 : 8'h7F;
      op({6'b001001, i[0], i[1], f}, 1'b0);
      `OCD_CHK(dec_byte, 1'b1)
      `OCD_CHK({dec_valid, instr_ready}, 2'b11)
      `OCD_CHK(dec_dest_file, i[0])
      `OCD_CHK(dec_file_addr, {i[1] ? 4'h5 : {4{i[0]}}, f})
    end
    for (i = 0; i < 8; i++) begin
      op({4'h8, i[2:0], 1'b1, 8'h33}, 1'b0);
      `OCD_CHK(dec_bit, 1'b1)
      `OCD_CHK(dec_bit_sel, i[2:0])
      `OCD_CHK(dec_file_addr, 12'h533)
    end
    op(16'h0E9C, 1'b0);
    `OCD_CHK(dec_lit_w, LW_8)
    `OCD_CHK(dec_literal[7:0], 8'h9C)
    for (i = 0; i < 4; i++) begin
      op({8'hEE, 2'b00, i[1:0], 4'hA}, 1'b0);
      op(16'hF0BC, 1'b0);
      `OCD_CHK(dec_lit_w, LW_12)
      `OCD_CHK(dec_literal[11:0], 12'hABC)
      `OCD_CHK(dec_ind_sel, i[1:0])
    end
    $display("t_fields done");
  endtask : t_fields

  task automatic t_ctrl;
    int s;
    op(16'hEF34, 1'b0);
    op(16'hF567, 1'b0);
    `OCD_CHK({dec_br_abs, dec_br_val}, {1'b1, 20'h56734})
    `OCD_CHK(dec_lit_w, LW_20)
    op(16'h2400, 1'b0);
    `OCD_CHK(dec_nop, 1'b1)
    op(16'hD7FF, 1'b0);
    `OCD_CHK({dec_br_rel, dec_br_val}, {1'b1, 20'hFFFFF})
    op(16'h0000, 1'b0);
    for (s = 0; s < 2; s++) begin
      op({`OCD_OP_CALL, s[0], 8'h12}, 1'b0);
      op(16'hF000, 1'b0);
      `OCD_CHK({dec_br_abs, dec_sh_save}, {1'b1, s[0]})
      op(16'h0000, 1'b0);
      op({`OCD_OP_RET, s[0]}, 1'b0);
      `OCD_CHK(dec_sh_rest, s[0])
      op(16'h0000, 1'b0);
    end
    op(16'hC123, 1'b0);
    op(16'hF456, 1'b0);
    `OCD_CHK({dec_move, dec_move_src, dec_move_dst}, 25'h1123456)
    op(16'hF789, 1'b0);
    `OCD_CHK({dec_nop, dec_move}, 2'b10)
    // Offset move through a nonzero pointer; first pass sets don't-cares
    @(posedge sys_clk);
    ind_ptr <= 12'h100;
    op(16'hEB85, 1'b0);
    op(16'hFF8A, 1'b0);
    `OCD_CHK({dec_move, dec_move_src, dec_move_dst}, 25'h110510A)
    op(16'hEB85, 1'b0);
    op(16'hF00A, 1'b0);
    `OCD_CHK({dec_move, dec_move_src, dec_move_dst}, 25'h110510A)
    op(16'hC123, 1'b0);
    op(16'h2400, 1'b0);
    `OCD_CHK(dec_nop, 1'b1)
    op(16'h2400, 1'b1);
    `OCD_CHK({dec_nop, dec_byte}, 2'b10)
    $display("t_ctrl done");
  endtask : t_ctrl

  task automatic t_tbl;
    int m;
    logic [20:0] p, a, np;
    // All four pointer modes, at the ends of the 21-bit range
    for (m = 0; m < 4; m++) begin
      p = (m == 2) ? 21'h000000 : 21'h1FFFFF;
      a = (m == 3) ? p + 21'h1 : p;
      np = (m == 0) ? p : (m == 2) ? p - 21'h1 : p + 21'h1;
      slow <= m[0];
      apb(1'b1, `OCD_OFS_TPTR, {11'h0, p});
      op({12'h000, 2'b10, m[1:0]}, 1'b0);
      wait_on(1'b0);
      `OCD_CHK({tbl_wr, tbl_addr}, {1'b0, a})
      wait_on(1'b1);
      apb(1'b0, `OCD_OFS_TPTR, 32'h0);
      `OCD_CHK(q[20:0], np)
      apb(1'b0, `OCD_OFS_TLAT, 32'h0);
      `OCD_CHK(q[7:0], a[7:0] ^ 8'h5A)
    end
    apb(1'b1, `OCD_OFS_TLAT, 32'h000000A5);
    apb(1'b1, `OCD_OFS_TPTR, 32'h0000ABCD);
    op(16'h000D, 1'b0);
    wait_on(1'b0);
    `OCD_CHK({tbl_wr, tbl_wdata, tbl_addr}, {1'b1, 8'hA5, 21'h00ABCD})
    @(posedge sys_clk);
    #1;
    `OCD_CHK(wr_byte, 8'hA5)
    $display("t_tbl done");
  endtask : t_tbl

  // Main sequence
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    cond_true = 1'b0;
    ind_ptr = 12'h000;
    slow = 1'b0;
    n_fail = 0;
    comparisons = 0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_fields();
    t_ctrl();
    apb(1'b1, `OCD_OFS_CTRL, 32'h0);
    op(16'h2400, 1'b0);
    `OCD_CHK(dec_nop, 1'b1)
    apb(1'b1, `OCD_OFS_CTRL, 32'h1);
    t_tbl();
    tally_and_finish();
  end
endmodule : cpu_opcode_field_decode_tb_top
